//--- adc_cfg_pkg.sv
// Shared constants and types for the converter configuration port controller
package adc_cfg_pkg;

   // ------------------------------------------------------------
   // Software register map
   // ------------------------------------------------------------
   localparam int REG_ADDR_W = 4;
   localparam int REG_DATA_W = 16;
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_START_ADDR = 4'h1;
   localparam logic [3:0] REG_STREAM_LEN = 4'h2;
   localparam logic [3:0] REG_STATUS = 4'h3;
   // Address bit 3 high selects the byte buffer, low bits pick the entry
   localparam int BUF_SEL_BIT = 3;

   // ------------------------------------------------------------
   // Control register fields
   // ------------------------------------------------------------
   localparam int CTRL_START = 0;
   localparam int CTRL_READ = 1;
   localparam int CTRL_LEN_LO = 2;
   localparam int CTRL_LSB_FIRST = 4;
   localparam int CTRL_STRAP_MODE = 5;
   localparam int CTRL_DCS_LEVEL = 6;
   localparam int CTRL_FMT_LEVEL = 7;
   localparam int CTRL_OUT_DISABLE = 8;
   localparam int CTRL_POWERDOWN = 9;
   localparam int CTRL_PAUSE = 10;
   // Stabiliser strap high, all else low, serial mode
   localparam logic [15:0] CTRL_RESET = 16'h0040;
   localparam logic [15:0] CTRL_WR_MASK = 16'h07FE;

   // ------------------------------------------------------------
   // Status register fields
   // ------------------------------------------------------------
   localparam int ST_BUSY = 0;
   localparam int ST_DONE = 1;

   // ------------------------------------------------------------
   // Frame layout
   // ------------------------------------------------------------
   localparam int INSTR_BITS = 16;
   localparam int BYTE_BITS = 8;
   localparam int ADDR_BITS = 13;
   localparam logic [1:0] LEN_STREAM = 2'b11;
   localparam logic [3:0] STREAM_LEN_RESET = 4'h1;
   localparam logic [4:0] INSTR_BITS_5 = 5'h10;
   localparam logic [4:0] BYTE_BITS_5 = 5'h08;

   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 100;
   localparam int SCLK_HALF_NS = 400;
   localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int HALF_W = 8;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_LOW = 3'b001,
      ST_HIGH = 3'b010,
      ST_PAUSE = 3'b011,
      ST_FINISH = 3'b100
   } state_t;

endpackage

//--- cfg_byte_buffer.sv
// Small byte buffer with one write port and two registered read ports
`timescale 1ns/1ps
`default_nettype none
module cfg_byte_buffer #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8,
   parameter int AW = 3
) (
   // Clock
   input wire logic clk,
   // Write port
   input wire logic wrEn,
   input wire logic [AW-1:0] wrAddr,
   input wire logic [WIDTH-1:0] wrData,
   // Read ports
   input wire logic [AW-1:0] rdAddrA,
   output logic [WIDTH-1:0] rdDataA,
   input wire logic [AW-1:0] rdAddrB,
   output logic [WIDTH-1:0] rdDataB
);

   logic [WIDTH-1:0] mem [DEPTH];

   always_ff @(posedge clk)
   begin
      if (wrEn)
      begin
         mem[wrAddr] <= wrData;
      end
   end

   always_ff @(posedge clk)
   begin
      rdDataA <= mem[rdAddrA];
      rdDataB <= mem[rdAddrB];
   end

endmodule
`default_nettype wire

//--- adc_config_serial_port.sv
// Host-side controller for the converter's three-wire configuration port
`timescale 1ns/1ps
`default_nettype none
module adc_config_serial_port #(
   parameter int BUF_DEPTH = 8,
   parameter int BUF_AW = 3
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Software register port
   input wire logic [adc_cfg_pkg::REG_ADDR_W-1:0] regAddr,
   input wire logic [adc_cfg_pkg::REG_DATA_W-1:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   output logic [adc_cfg_pkg::REG_DATA_W-1:0] regRdata,
   // Device pins
   output logic portSelectN,
   output logic shiftClockFormatStrap,
   input wire logic bidirDataStabiliserStrapIn,
   output logic bidirDataStabiliserStrapOut,
   output logic bidirDataStabiliserStrapOe,
   output logic outputDisablePin,
   output logic powerdownPin
);

   localparam int HALF_BITS = adc_cfg_pkg::HALF_W;
   localparam logic [adc_cfg_pkg::HALF_W-1:0] HALF_LAST =
      HALF_BITS'(adc_cfg_pkg::SCLK_HALF_CYC - 1);

   // ------------------------------------------------------------
   // Reset release and pin synchronisers
   // ------------------------------------------------------------
   logic rstMeta_ff, rstSync_ff, rstn;
   logic sdioMeta_ff, sdioSync_ff;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rstMeta_ff <= 1'b0;
         rstSync_ff <= 1'b0;
      end
      else
      begin
         rstMeta_ff <= 1'b1;
         rstSync_ff <= rstMeta_ff;
      end
   end
   assign rstn = rstSync_ff;

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         sdioMeta_ff <= 1'b0;
         sdioSync_ff <= 1'b0;
      end
      else
      begin
         sdioMeta_ff <= bidirDataStabiliserStrapIn;
         sdioSync_ff <= sdioMeta_ff;
      end
   end

   // ------------------------------------------------------------
   // Software registers
   // ------------------------------------------------------------
   logic [15:0] ctrl_ff;
   logic [adc_cfg_pkg::ADDR_BITS-1:0] startAddr_ff;
   logic [3:0] streamLen_ff;
   logic done_ff, donePulse, busy, startPulse, swBufWr, ctrlWr;
   logic [15:0] ctrlNow;
   adc_cfg_pkg::state_t state_ff;

   assign busy = (state_ff != adc_cfg_pkg::ST_IDLE);
   assign ctrlWr = regWr && (regAddr == adc_cfg_pkg::REG_CTRL);
   // A start write carries its own settings, so the frame takes them from the write
   assign ctrlNow = ctrlWr ? (regWdata & adc_cfg_pkg::CTRL_WR_MASK) : ctrl_ff;
   assign swBufWr = regWr && regAddr[adc_cfg_pkg::BUF_SEL_BIT];
   // Starts are ignored while a frame runs or the pins are in static mode
   assign startPulse = ctrlWr && regWdata[adc_cfg_pkg::CTRL_START] && !busy &&
      !ctrlNow[adc_cfg_pkg::CTRL_STRAP_MODE];

   // Frame settings are latched at start, so ctrl may change mid-frame
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         ctrl_ff <= adc_cfg_pkg::CTRL_RESET;
         startAddr_ff <= '0;
         streamLen_ff <= adc_cfg_pkg::STREAM_LEN_RESET;
      end
      else if (regWr)
      begin
         if (regAddr == adc_cfg_pkg::REG_CTRL)
            ctrl_ff <= regWdata & adc_cfg_pkg::CTRL_WR_MASK;
         if (regAddr == adc_cfg_pkg::REG_START_ADDR)
            startAddr_ff <= regWdata[adc_cfg_pkg::ADDR_BITS-1:0];
         if (regAddr == adc_cfg_pkg::REG_STREAM_LEN)
            streamLen_ff <= regWdata[3:0];
      end
   end

   // Completion flag: a new completion wins over a clear in the same cycle
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         done_ff <= 1'b0;
      else if (donePulse)
         done_ff <= 1'b1;
      else if (regWr && regAddr == adc_cfg_pkg::REG_STATUS &&
               regWdata[adc_cfg_pkg::ST_DONE])
         done_ff <= 1'b0;
   end

   // ------------------------------------------------------------
   // Byte buffer
   // ------------------------------------------------------------
   logic [7:0] memRdA, memRdB, rxNew;
   logic [BUF_AW-1:0] nextByte_ff, rxIdx_ff;
   logic engWr;

   cfg_byte_buffer #(
      .WIDTH(adc_cfg_pkg::BYTE_BITS),
      .DEPTH(BUF_DEPTH),
      .AW(BUF_AW)
   ) u_buf (
      .clk(clk),
      .wrEn(engWr || (swBufWr && !busy)),
      .wrAddr(engWr ? rxIdx_ff : regAddr[BUF_AW-1:0]),
      .wrData(engWr ? rxNew : regWdata[7:0]),
      .rdAddrA(regAddr[BUF_AW-1:0]),
      .rdDataA(memRdA),
      .rdAddrB(nextByte_ff),
      .rdDataB(memRdB)
   );

   // ------------------------------------------------------------
   // Read-back, data one cycle after the strobe
   // ------------------------------------------------------------
   logic [15:0] regRd_ff;
   logic selBuf_ff;

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         regRd_ff <= '0;
         selBuf_ff <= 1'b0;
      end
      else
      begin
         selBuf_ff <= regRd && regAddr[adc_cfg_pkg::BUF_SEL_BIT];
         regRd_ff <= '0;
         if (regRd)
         begin
            case (regAddr)
               adc_cfg_pkg::REG_CTRL: regRd_ff <= ctrl_ff;
               adc_cfg_pkg::REG_START_ADDR: regRd_ff <= {3'b000, startAddr_ff};
               adc_cfg_pkg::REG_STREAM_LEN: regRd_ff <= {12'h000, streamLen_ff};
               adc_cfg_pkg::REG_STATUS: regRd_ff <= {14'h0000, done_ff, busy};
               default: regRd_ff <= '0;
            endcase
         end
      end
   end
   // Buffer entries come from the memory's own output register
   assign regRdata = selBuf_ff ? {8'h00, memRdA} : regRd_ff;

   // ------------------------------------------------------------
   // Frame engine
   // ------------------------------------------------------------
   logic [adc_cfg_pkg::HALF_W-1:0] halfCnt_ff;
   logic [4:0] bitsLeft_ff;
   logic [3:0] bytesLeft_ff, frameBytes_ff;
   logic [15:0] shift_ff, nxtShift, loadWord;
   logic [7:0] rx_ff;
   logic inInstr_ff, frameRead_ff, frameLsb_ff, framePause_ff, halfDone, unitEnd, lastByte;
   logic [1:0] lenCode;
   logic [3:0] startBytes;

   assign lenCode = ctrlNow[adc_cfg_pkg::CTRL_LEN_LO +: 2];
   assign startBytes = (lenCode == adc_cfg_pkg::LEN_STREAM) ? streamLen_ff :
      {2'b00, lenCode} + 4'h1;
   assign halfDone = (halfCnt_ff == HALF_LAST);
   assign unitEnd = (bitsLeft_ff == 5'h01);
   assign lastByte = (bytesLeft_ff == 4'h1);
   assign nxtShift = frameLsb_ff ? (shift_ff >> 1) : (shift_ff << 1);
   assign rxNew = frameLsb_ff ? {sdioSync_ff, rx_ff[7:1]} :
      {rx_ff[6:0], sdioSync_ff};
   assign loadWord = frameLsb_ff ? {8'h00, memRdB} : {memRdB, 8'h00};
   assign engWr = (state_ff == adc_cfg_pkg::ST_HIGH) && halfDone && unitEnd &&
      !inInstr_ff && frameRead_ff;
   assign donePulse = (state_ff == adc_cfg_pkg::ST_FINISH) && halfDone;

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         state_ff <= adc_cfg_pkg::ST_IDLE;
         halfCnt_ff <= '0;
         bitsLeft_ff <= '0;
         bytesLeft_ff <= '0;
         frameBytes_ff <= '0;
         shift_ff <= '0;
         rx_ff <= '0;
         inInstr_ff <= 1'b0;
         frameRead_ff <= 1'b0;
         frameLsb_ff <= 1'b0;
         framePause_ff <= 1'b0;
         nextByte_ff <= '0;
         rxIdx_ff <= '0;
         portSelectN <= 1'b1;
         shiftClockFormatStrap <= 1'b0;
         bidirDataStabiliserStrapOut <= 1'b0;
         bidirDataStabiliserStrapOe <= 1'b0;
      end
      else
      begin
         halfCnt_ff <= halfDone ? '0 : halfCnt_ff + 1'b1;
         case (state_ff)
            adc_cfg_pkg::ST_IDLE:
            begin
               halfCnt_ff <= '0;
               nextByte_ff <= '0;
               rxIdx_ff <= '0;
               if (ctrl_ff[adc_cfg_pkg::CTRL_STRAP_MODE])
               begin
                  // Select parked high, clock and data pins carry strap levels
                  portSelectN <= 1'b1;
                  shiftClockFormatStrap <= ctrl_ff[adc_cfg_pkg::CTRL_FMT_LEVEL];
                  bidirDataStabiliserStrapOut <= ctrl_ff[adc_cfg_pkg::CTRL_DCS_LEVEL];
                  bidirDataStabiliserStrapOe <= 1'b1;
               end
               else if (startPulse)
               begin
                  frameRead_ff <= ctrlNow[adc_cfg_pkg::CTRL_READ];
                  frameLsb_ff <= ctrlNow[adc_cfg_pkg::CTRL_LSB_FIRST];
                  framePause_ff <= ctrlNow[adc_cfg_pkg::CTRL_PAUSE];
                  frameBytes_ff <= startBytes;
                  bytesLeft_ff <= startBytes;
                  bitsLeft_ff <= adc_cfg_pkg::INSTR_BITS_5;
                  inInstr_ff <= 1'b1;
                  shift_ff <= {ctrlNow[adc_cfg_pkg::CTRL_READ], lenCode, startAddr_ff};
                  bidirDataStabiliserStrapOut <= ctrlNow[adc_cfg_pkg::CTRL_LSB_FIRST] ?
                     startAddr_ff[0] : ctrlNow[adc_cfg_pkg::CTRL_READ];
                  bidirDataStabiliserStrapOe <= 1'b1;
                  portSelectN <= 1'b0;
                  shiftClockFormatStrap <= 1'b0;
                  state_ff <= adc_cfg_pkg::ST_LOW;
               end
               else
               begin
                  // Idle serial port: everything quiet, data pin released
                  portSelectN <= 1'b1;
                  shiftClockFormatStrap <= 1'b0;
                  bidirDataStabiliserStrapOe <= 1'b0;
               end
            end
            adc_cfg_pkg::ST_LOW:
            begin
               if (halfDone)
               begin
                  shiftClockFormatStrap <= 1'b1;
                  state_ff <= adc_cfg_pkg::ST_HIGH;
               end
            end
            adc_cfg_pkg::ST_HIGH:
            begin
               if (halfDone)
               begin
                  shiftClockFormatStrap <= 1'b0;
                  rx_ff <= rxNew;
                  bitsLeft_ff <= bitsLeft_ff - 5'h01;
                  state_ff <= adc_cfg_pkg::ST_LOW;
                  if (!unitEnd)
                  begin
                     shift_ff <= nxtShift;
                     bidirDataStabiliserStrapOut <= frameLsb_ff ? nxtShift[0] : nxtShift[15];
                  end
                  else if (!inInstr_ff && lastByte)
                  begin
                     state_ff <= adc_cfg_pkg::ST_FINISH;
                  end
                  else
                  begin
                     bitsLeft_ff <= adc_cfg_pkg::BYTE_BITS_5;
                     shift_ff <= loadWord;
                     nextByte_ff <= nextByte_ff + 1'b1;
                     bidirDataStabiliserStrapOut <= frameLsb_ff ? loadWord[0] : loadWord[15];
                     if (inInstr_ff)
                     begin
                        inInstr_ff <= 1'b0;
                        // Release the data pin so the device can answer
                        bidirDataStabiliserStrapOe <= !frameRead_ff;
                     end
                     else
                     begin
                        bytesLeft_ff <= bytesLeft_ff - 4'h1;
                        rxIdx_ff <= rxIdx_ff + 1'b1;
                     end
                     if (framePause_ff)
                     begin
                        portSelectN <= 1'b1;
                        state_ff <= adc_cfg_pkg::ST_PAUSE;
                     end
                  end
               end
            end
            adc_cfg_pkg::ST_PAUSE:
            begin
               // Select returns low a full half period before the next rise
               if (halfDone)
               begin
                  portSelectN <= 1'b0;
                  state_ff <= adc_cfg_pkg::ST_LOW;
               end
            end
            adc_cfg_pkg::ST_FINISH:
            begin
               if (halfDone)
               begin
                  portSelectN <= 1'b1;
                  bidirDataStabiliserStrapOe <= 1'b0;
                  state_ff <= adc_cfg_pkg::ST_IDLE;
               end
            end
            default:
            begin
               state_ff <= adc_cfg_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // Static control pins: software must leave them low to use register control
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         outputDisablePin <= 1'b0;
         powerdownPin <= 1'b0;
      end
      else
      begin
         outputDisablePin <= ctrl_ff[adc_cfg_pkg::CTRL_OUT_DISABLE];
         powerdownPin <= ctrl_ff[adc_cfg_pkg::CTRL_POWERDOWN];
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   logic [7:0] riseCnt_ff;

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         riseCnt_ff <= '0;
      else if (startPulse)
         riseCnt_ff <= '0;
      else if (state_ff == adc_cfg_pkg::ST_LOW && halfDone)
         riseCnt_ff <= riseCnt_ff + 8'h01;
   end

   a_first_edge: assert property (@(posedge clk) disable iff (!rstn)
      $fell(portSelectN) |-> !shiftClockFormatStrap [*3])
      else $error("clock rose too soon after select fell");

   a_clock_gated: assert property (@(posedge clk) disable iff (!rstn)
      (portSelectN && !ctrl_ff[adc_cfg_pkg::CTRL_STRAP_MODE] &&
      !$past(ctrl_ff[adc_cfg_pkg::CTRL_STRAP_MODE])) |-> !shiftClockFormatStrap)
      else $error("shift clock high while select high");

   a_frame_length: assert property (@(posedge clk) disable iff (!rstn)
      donePulse |-> riseCnt_ff == 8'(adc_cfg_pkg::INSTR_BITS) + {1'b0, frameBytes_ff, 3'b000})
      else $error("frame bit count differs from instruction length");

   a_rw_first: assert property (@(posedge clk) disable iff (!rstn)
      startPulse |=> bidirDataStabiliserStrapOut == (ctrl_ff[adc_cfg_pkg::CTRL_LSB_FIRST] ?
      startAddr_ff[0] : ctrl_ff[adc_cfg_pkg::CTRL_READ]))
      else $error("first instruction bit is wrong");

   a_turnaround: assert property (@(posedge clk) disable iff (!rstn)
      ($fell(bidirDataStabiliserStrapOe) && busy) |-> frameRead_ff &&
      riseCnt_ff == 8'(adc_cfg_pkg::INSTR_BITS))
      else $error("data pin released at the wrong point");

   a_write_drives: assert property (@(posedge clk) disable iff (!rstn)
      (busy && !frameRead_ff && !$past(startPulse)) |-> bidirDataStabiliserStrapOe)
      else $error("write frame left the data pin undriven");

   a_pause_bytes: assert property (@(posedge clk) disable iff (!rstn)
      ($rose(portSelectN) && state_ff == adc_cfg_pkg::ST_PAUSE) |->
      riseCnt_ff[2:0] == 3'b000 ##1 portSelectN [*3])
      else $error("pause not on a byte boundary");

   a_strap_pins: assert property (@(posedge clk) disable iff (!rstn)
      (ctrl_ff[adc_cfg_pkg::CTRL_STRAP_MODE] && !busy) |=>
      portSelectN && bidirDataStabiliserStrapOe &&
      shiftClockFormatStrap == $past(ctrl_ff[adc_cfg_pkg::CTRL_FMT_LEVEL]) &&
      bidirDataStabiliserStrapOut == $past(ctrl_ff[adc_cfg_pkg::CTRL_DCS_LEVEL]))
      else $error("static pin levels do not follow control");

endmodule
`default_nettype wire

//--- cfg_port_device_model.sv
// Behavioural model of the converter's serial configuration port
`timescale 1ns/1ps
`default_nettype none
module cfg_port_device_model (
   // Serial pins
   input wire logic portSelectN,
   input wire logic shiftClock,
   input wire logic dataIn,
   output logic dataOut,
   output logic dataOe,
   // Static pins
   input wire logic outDisable,
   input wire logic powerdown,
   output logic stabOn,
   output logic twosComp,
   output logic outputsOff,
   output logic poweredDown
);
   // ------------------------------------------------------------
   // Register space and frame tracking
   // ------------------------------------------------------------
   logic [7:0] mem [0:7];
   logic [15:0] instr = 16'h0000;
   logic [7:0] sh = 8'h00;
   logic lsbFirst = 1'b0;
   logic [2:0] ptr;
   int bitCnt = 0;
   initial
   begin
      for (int k = 0; k < 8; k++) mem[k] = 8'h00;
      mem[0] = 8'h18;
      dataOut = 1'b0;
      dataOe = 1'b0;
   end
   // Strap levels count only while deselected
   assign stabOn = portSelectN ? dataIn : 1'b1;
   assign twosComp = portSelectN ? shiftClock : 1'b0;
   assign outputsOff = outDisable;
   assign poweredDown = powerdown;
   assign ptr = instr[2:0] + 3'((bitCnt - 16) / 8);
   // Streaming ends only at a select fall, so a pause inside a stream is not modelled
   function automatic logic frameDone();
      return bitCnt >= 16 && (instr[14:13] == 2'b11 ||
         bitCnt >= 24 + 8 * instr[14:13]);
   endfunction
   always @(negedge portSelectN)
      if (frameDone()) bitCnt = 0;
   always @(posedge shiftClock)
      if (!portSelectN)
      begin
         if (bitCnt < 16)
            instr = lsbFirst ? {dataIn, instr[15:1]} : {instr[14:0], dataIn};
         else if (!instr[15])
         begin
            sh = lsbFirst ? {dataIn, sh[7:1]} : {sh[6:0], dataIn};
            if (bitCnt % 8 == 7)
            begin
               mem[ptr] = sh;
               if (ptr == 3'h0) lsbFirst = sh[6] | sh[1];
            end
         end
         bitCnt++;
      end
   always @(negedge shiftClock)
      if (!portSelectN && instr[15] && bitCnt >= 16)
      begin
         dataOe = 1'b1;
         dataOut = mem[ptr][lsbFirst ? bitCnt % 8 : 7 - bitCnt % 8];
      end
   always @(posedge portSelectN)
      dataOe = 1'b0;
endmodule
`default_nettype wire

//--- adc_config_serial_port_tb_top.sv
// Self-checking bench for the configuration port controller
`timescale 1ns/1ps
`default_nettype none
module adc_config_serial_port_tb_top;
   // ------------------------------------------------------------
   // Bench signals, model and helper tasks
   // ------------------------------------------------------------
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [3:0] regAddr = 4'h0;
   logic [15:0] regWdata = 16'h0000;
   logic regWr = 1'b0;
   logic regRd = 1'b0;
   logic [15:0] regRdata, v;
   logic selN, sck, hOut, hOe, dOut, dOe, oDis, powerdown_pin, stabOn, twos, oOff, pDn;
   logic floatLvl = 1'b0;
   wire logic sdio;
   int fail_count = 0;
   int cmp_count = 0;
   always #50 clk = ~clk;
   // An undriven line wanders so a stale level is never trusted
   assign sdio = hOe ? hOut : (dOe ? dOut : floatLvl);
   always @(posedge clk) floatLvl <= ~sdio;
   adc_config_serial_port i_adc_config_serial_port (.clk(clk), .rst_n(rst_n), .regAddr(regAddr),
      .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
      .portSelectN(selN), .shiftClockFormatStrap(sck), .bidirDataStabiliserStrapIn(sdio),
      .bidirDataStabiliserStrapOut(hOut), .bidirDataStabiliserStrapOe(hOe),
      .outputDisablePin(oDis), .powerdownPin(powerdown_pin));
   cfg_port_device_model i_cfg_port_device_model (.portSelectN(selN), .shiftClock(sck),
      .dataIn(sdio), .dataOut(dOut), .dataOe(dOe), .outDisable(oDis), .powerdown(powerdown_pin),
      .stabOn(stabOn), .twosComp(twos), .outputsOff(oOff), .poweredDown(pDn));
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         fail_count++;
         $display("ERROR %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic print_verdict();
      $display("Compares %0d, mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      regAddr <= a;
      regWdata <= d;
      regWr <= 1'b1;
      @(posedge clk);
      regWr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, output logic [15:0] d);
      @(posedge clk);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge clk);
      regRd <= 1'b0;
      #1 d = regRdata;
   endtask
   // One frame, then the port idles until the next request
   task automatic run(input logic [15:0] ctrl, input logic [15:0] addr);
      int n;
      wr(adc_cfg_pkg::REG_START_ADDR, addr);
      wr(adc_cfg_pkg::REG_CTRL, ctrl | 16'h0001);
      for (n = 0; n < 2000; n++)
      begin
         rd(adc_cfg_pkg::REG_STATUS, v);
         if (v[adc_cfg_pkg::ST_DONE] === 1'b1) break;
      end
      if (n == 2000)
      begin
         fail_count++;
         print_verdict();
      end
      wr(adc_cfg_pkg::REG_STATUS, 16'h0002);
   endtask
   function automatic logic [15:0] mb(input int a);
      return {8'h00, i_cfg_port_device_model.mem[a]};
   endfunction
   task automatic t_reset();
      rd(adc_cfg_pkg::REG_CTRL, v);
      chk(v, adc_cfg_pkg::CTRL_RESET);
      rd(4'h4, v);
      chk(v, 16'h0000);
      chk({13'h0000, selN, oDis, powerdown_pin}, 16'h0004);
   endtask
   task automatic t_write();
      wr(4'h8, 16'h00A5);
      run(16'h0040, 16'h0003);
      chk(mb(3), 16'h00A5);
      for (int k = 0; k < 3; k++) wr(4'(8 + k), 16'(8'h11 * (k + 1)));
      run(16'h0448, 16'h0004);
      for (int k = 0; k < 3; k++) chk(mb(4 + k), 16'(8'h11 * (k + 1)));
      chk(mb(7), 16'h0000);
   endtask
   task automatic t_read();
      run(16'h0046, 16'h0003);
      rd(4'h8, v);
      chk(v, 16'h00A5);
      rd(4'h9, v);
      chk(v, 16'h0011);
   endtask
   task automatic t_stream();
      wr(adc_cfg_pkg::REG_STREAM_LEN, 16'h0003);
      for (int k = 0; k < 3; k++) wr(4'(8 + k), 16'(8'hC0 + k));
      run(16'h004C, 16'h0001);
      for (int k = 0; k < 3; k++) chk(mb(1 + k), 16'(8'hC0 + k));
      chk(mb(4), 16'h0011);
   endtask
   task automatic t_lsb();
      wr(4'h8, 16'h0042);
      run(16'h0040, 16'h0000);
      wr(4'h8, 16'h000D);
      run(16'h0050, 16'h0005);
      chk(mb(5), 16'h000D);
      wr(4'h8, 16'h0000);
      run(16'h0052, 16'h0005);
      rd(4'h8, v);
      chk(v, 16'h000D);
   endtask
   // Strap mode: select held high as a board would tie it
   task automatic t_strap();
      wr(adc_cfg_pkg::REG_CTRL, 16'h03A0);
      repeat (3) @(posedge clk);
      chk({10'h000, hOut, selN, sck, hOe, oDis, powerdown_pin}, 16'h001F);
      chk({12'h000, stabOn, twos, oOff, pDn}, 16'h0007);
      wr(adc_cfg_pkg::REG_CTRL, 16'h03A1);
      rd(adc_cfg_pkg::REG_STATUS, v);
      chk(v, 16'h0000);
      wr(adc_cfg_pkg::REG_CTRL, 16'h0060);
      repeat (3) @(posedge clk);
      chk({12'h000, stabOn, twos, oOff, pDn}, 16'h0008);
   endtask
   initial
   begin
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      t_reset();
      t_write();
      t_read();
      t_stream();
      t_lsb();
      t_strap();
      print_verdict();
   end
endmodule
`default_nettype wire
